// ==== include/timer16_pkg.sv ====
/*
 * Constants for the 16-bit timer compare and waveform block: waveform mode
 * codes, fixed ceilings, output action codes and reset values.
 * Assumes it is compiled before any module that imports it.
 */
package timer16_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int COUNT_W  = 16;
	localparam int BYTE_W   = 8;
	localparam int MODE_W   = 4;
	localparam int ACTION_W = 2;

	// ----------------------------------------------------------------
	// waveform mode codes
	// ----------------------------------------------------------------
	localparam logic [MODE_W-1:0] MODE_NORMAL      = 4'h0;
	localparam logic [MODE_W-1:0] MODE_CLEAR_A     = 4'h4;
	localparam logic [MODE_W-1:0] MODE_FAST_8      = 4'h5;
	localparam logic [MODE_W-1:0] MODE_FAST_9      = 4'h6;
	localparam logic [MODE_W-1:0] MODE_FAST_10     = 4'h7;
	localparam logic [MODE_W-1:0] MODE_CLEAR_CAP   = 4'hC;
	localparam logic [MODE_W-1:0] MODE_RESERVED    = 4'hD;
	localparam logic [MODE_W-1:0] MODE_FAST_CAP    = 4'hE;
	localparam logic [MODE_W-1:0] MODE_FAST_A      = 4'hF;

	// ----------------------------------------------------------------
	// counter limits
	// ----------------------------------------------------------------
	localparam logic [COUNT_W-1:0] COUNT_MAX    = 16'hFFFF;
	localparam logic [COUNT_W-1:0] COUNT_BOTTOM = 16'h0000;
	localparam logic [COUNT_W-1:0] TOP_FIXED_8  = 16'h00FF;
	localparam logic [COUNT_W-1:0] TOP_FIXED_9  = 16'h01FF;
	localparam logic [COUNT_W-1:0] TOP_FIXED_10 = 16'h03FF;

	// ----------------------------------------------------------------
	// output action codes
	// ----------------------------------------------------------------
	localparam logic [ACTION_W-1:0] ACT_NONE   = 2'h0;
	localparam logic [ACTION_W-1:0] ACT_TOGGLE = 2'h1;
	localparam logic [ACTION_W-1:0] ACT_CLEAR  = 2'h2;
	localparam logic [ACTION_W-1:0] ACT_SET    = 2'h3;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [COUNT_W-1:0] COMPARE_RESET = 16'h0000;
	localparam logic [BYTE_W-1:0]  LATCH_RESET   = 8'h00;
	localparam logic               WAVE_RESET    = 1'b0;
	localparam logic               FORCE_READ    = 1'b0;

endpackage

// ==== src/timer16_compare_waveform.sv ====
/*
 * Output compare unit A and waveform generator of a 16-bit timer: compare
 * value with high-byte latch write path, force strobe, match blocking after
 * a counter write, port pin override; normal, clear-on-match and
 * single-slope fast PWM modes.
 * Assumes all inputs come from logic on ref_clk, timer_tick is a one-cycle
 * prescaled timer enable, and capture_value comes from the capture unit.
 */
// Functional notes
// - CPU reaches buffer when buffered, else live
// - compare reads direct, no high-byte latch
// - high byte latched; low write copies both
// - force updates wave in non-PWM modes only, no flag/counter
// - counter write blocks matches next timer cycle
// - counter written at ceiling runs to max
// - wave holds across waveform mode changes
// - action field unbuffered, applies next match
// - reset clears wave flip-flop
// - nonzero action overrides port value on pin
// - action field never touches capture logic
// - action zero leaves wave unchanged
// - normal mode counts up, wraps at max
// - normal overflow flag set on zero
// - modes 4/12 clear on A/capture ceiling
// - missed unbuffered ceiling runs to max first
// - clear-on-match action 1 toggles wave
// - clear-on-match overflow on max to zero
// - fast PWM counts bottom to ceiling, restarts
// - fast PWM sets/clears at match and bottom
// - buffered in PWM; transfer at ceiling in fast PWM only
// - match flag set next timer cycle; cleared
`timescale 1ns/100ps

module timer16_compare_waveform
	import timer16_pkg::*;
(
	input  wire logic                           ref_clk,
	input  wire logic                           sys_rst,
	input  wire logic                           timer_tick,
	input  wire logic [timer16_pkg::MODE_W-1:0]   waveform_mode_field,
	input  wire logic [timer16_pkg::ACTION_W-1:0] output_action_field,
	input  wire logic                           compare_value_high,
	input  wire logic                           compare_value_low,
	input  wire logic [timer16_pkg::BYTE_W-1:0]   cpu_wdata,
	output logic      [timer16_pkg::COUNT_W-1:0]  compare_read_value,
	input  wire logic                           counter_write,
	input  wire logic [timer16_pkg::COUNT_W-1:0]  counter_wdata,
	output logic      [timer16_pkg::COUNT_W-1:0]  counter_value,
	input  wire logic [timer16_pkg::COUNT_W-1:0]  capture_value_reg,
	input  wire logic                           force_match_strobe,
	output logic                                force_match_read,
	output logic                                match_flag,
	input  wire logic                           match_flag_clear,
	output logic                                overflow_flag,
	input  wire logic                           overflow_flag_clear,
	input  wire logic                           port_out_value,
	input  wire logic                           pin_direction_bit,
	output logic                                pin_level,
	output logic                                pin_drive_n,
	output logic                                unit_a_wave_output
);
	import timer16_pkg::*;

	// ----------------------------------------------------------------
	// mode decoding
	// ----------------------------------------------------------------
	function automatic logic is_pwm(input logic [MODE_W-1:0] mode);
		is_pwm = !(mode == MODE_NORMAL || mode == MODE_CLEAR_A ||
			mode == MODE_CLEAR_CAP || mode == MODE_RESERVED);
	endfunction

	function automatic logic is_fast(input logic [MODE_W-1:0] mode);
		is_fast = (mode == MODE_FAST_8) || (mode == MODE_FAST_9) ||
			(mode == MODE_FAST_10) || (mode == MODE_FAST_CAP) ||
			(mode == MODE_FAST_A);
	endfunction

	function automatic logic non_pwm_action(input logic [ACTION_W-1:0] act,
		input logic cur);
		unique case (act)
			ACT_NONE:   non_pwm_action = cur;
			ACT_TOGGLE: non_pwm_action = ~cur;
			ACT_CLEAR:  non_pwm_action = 1'b0;
			ACT_SET:    non_pwm_action = 1'b1;
		endcase
	endfunction

	logic [COUNT_W-1:0] compare_live;
	logic [COUNT_W-1:0] compare_buffer;
	logic [BYTE_W-1:0]  high_latch;
	logic               blocked;
	logic               pwm;
	logic               fast;
	logic [COUNT_W-1:0] top_value;
	logic               top_hit;
	logic               compare_hit;
	logic               overflow_event;

	assign pwm  = is_pwm(waveform_mode_field);
	assign fast = is_fast(waveform_mode_field);

	// capture value only feeds the ceiling; action field has no path here
	always_comb
	begin
		unique case (waveform_mode_field)
			MODE_CLEAR_A:   top_value = compare_live;
			MODE_CLEAR_CAP: top_value = capture_value_reg;
			MODE_FAST_8:    top_value = TOP_FIXED_8;
			MODE_FAST_9:    top_value = TOP_FIXED_9;
			MODE_FAST_10:   top_value = TOP_FIXED_10;
			MODE_FAST_CAP:  top_value = capture_value_reg;
			MODE_FAST_A:    top_value = compare_live;
			default:        top_value = COUNT_MAX;
		endcase
	end

	// exact equality only: a ceiling below the count is missed
	assign top_hit = timer_tick && !blocked && (waveform_mode_field != MODE_NORMAL) &&
		(counter_value == top_value);
	assign compare_hit = timer_tick && !blocked && (counter_value == compare_live);

	// overflow: at ceiling in fast PWM, else on max to zero
	assign overflow_event = timer_tick && !counter_write &&
		(fast ? top_hit : (counter_value == COUNT_MAX));

	// ----------------------------------------------------------------
	// compare value and high-byte latch
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			high_latch <= LATCH_RESET;
		else if (compare_value_high)
			high_latch <= cpu_wdata;
	end

	// buffer transfer at the ceiling keeps fast PWM pulses glitch-free
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			compare_live   <= COMPARE_RESET;
			compare_buffer <= COMPARE_RESET;
		end
		else
		begin
			if (compare_value_low && pwm)
				compare_buffer <= {high_latch, cpu_wdata};
			if (compare_value_low && !pwm)
				compare_live <= {high_latch, cpu_wdata};
			else if (fast && top_hit && !counter_write)
				compare_live <= compare_buffer;
		end
	end

	// reads bypass the latch; the timer never changes this value
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			compare_read_value <= COMPARE_RESET;
		else
			compare_read_value <= pwm ? compare_buffer : compare_live;
	end

	assign force_match_read = FORCE_READ;

	// ----------------------------------------------------------------
	// counter and match blocking
	// ----------------------------------------------------------------
	// block stays armed until a timer tick, so a stopped timer is covered too
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			blocked <= 1'b0;
		else if (counter_write)
			blocked <= 1'b1;
		else if (timer_tick)
			blocked <= 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			counter_value <= COUNT_BOTTOM;
		else if (counter_write)
			counter_value <= counter_wdata;
		else if (timer_tick)
		begin
			if (top_hit)
				counter_value <= COUNT_BOTTOM;
			else
				counter_value <= counter_value + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// flags: a set in the clearing cycle wins
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			match_flag <= 1'b0;
		else if (compare_hit)
			match_flag <= 1'b1;
		else if (match_flag_clear)
			match_flag <= 1'b0;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			overflow_flag <= 1'b0;
		else if (overflow_event)
			overflow_flag <= 1'b1;
		else if (overflow_flag_clear)
			overflow_flag <= 1'b0;
	end

	// ----------------------------------------------------------------
	// waveform generator
	// ----------------------------------------------------------------
	// action field read live, never buffered mode changes leave it alone
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
			unit_a_wave_output <= WAVE_RESET;
		else if (!pwm)
		begin
			if (compare_hit || force_match_strobe)
				unit_a_wave_output <= non_pwm_action(output_action_field,
					unit_a_wave_output);
		end
		else if (fast)
		begin
			if (top_hit && output_action_field[1])
				unit_a_wave_output <= ~output_action_field[0];
			else if (compare_hit)
			begin
				unique case (output_action_field)
					ACT_TOGGLE:
						if (waveform_mode_field == MODE_FAST_A)
							unit_a_wave_output <= ~unit_a_wave_output;
					ACT_CLEAR: unit_a_wave_output <= 1'b0;
					ACT_SET:   unit_a_wave_output <= 1'b1;
					ACT_NONE:  unit_a_wave_output <= unit_a_wave_output;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// port pin
	// ----------------------------------------------------------------
	// direction stays with software, so wave can be primed before driving
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			pin_level   <= 1'b0;
			pin_drive_n <= 1'b1;
		end
		else
		begin
			pin_level   <= (output_action_field != ACT_NONE) ?
				unit_a_wave_output : port_out_value;
			pin_drive_n <= ~pin_direction_bit;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_latch_to_live: assert property (
		compare_value_low && !pwm && !compare_value_high
		|=> compare_live == {$past(high_latch), $past(cpu_wdata)})
		else $error("low write did not merge latched high byte");

	a_force_no_flag: assert property (
		force_match_strobe && !pwm && !compare_hit && !match_flag
		|=> !match_flag)
		else $error("force strobe set the match flag");

	a_write_blocks: assert property (
		counter_write ##1 (timer_tick && !counter_write) |-> !compare_hit)
		else $error("match seen in the tick after a counter write");

	// own disable: the default one would switch this check off whenever reset is high
	a_wave_reset: assert property (@(posedge ref_clk) disable iff (1'b0)
		sys_rst |=> !unit_a_wave_output)
		else $error("wave output not cleared by reset");

	a_action_zero: assert property (
		output_action_field == ACT_NONE && (!fast || !top_hit)
		|=> $stable(unit_a_wave_output))
		else $error("wave changed with action zero");

	a_normal_wrap: assert property (
		waveform_mode_field == MODE_NORMAL && timer_tick && !counter_write &&
		counter_value == COUNT_MAX
		|=> counter_value == COUNT_BOTTOM && overflow_flag)
		else $error("normal mode did not wrap with overflow");

	a_ctc_clear: assert property (
		waveform_mode_field == MODE_CLEAR_A && top_hit && !counter_write
		|=> counter_value == COUNT_BOTTOM)
		else $error("clear-on-match did not clear counter");

	a_match_flag: assert property (
		compare_hit |=> match_flag ##1 (match_flag || $past(match_flag_clear)))
		else $error("match flag not set after match");

	a_pin_override: assert property (
		output_action_field != ACT_NONE |=> pin_level == $past(unit_a_wave_output)
		&& pin_drive_n == !$past(pin_direction_bit))
		else $error("pin not overridden by wave output");

	a_pwm_bottom: assert property (
		fast && top_hit && output_action_field == ACT_CLEAR
		|=> unit_a_wave_output)
		else $error("non-inverting fast PWM not set at bottom");

	a_pwm_match_clear: assert property (
		fast && compare_hit && !top_hit && output_action_field == ACT_CLEAR
		|=> !unit_a_wave_output)
		else $error("non-inverting fast PWM not cleared at match");

	a_block_run: assert property (
		counter_write ##1 (timer_tick && !counter_write)
		|=> counter_value == $past(counter_value) + 16'h0001)
		else $error("blocked tick did not simply count on");

	a_ctc_toggle: assert property (
		waveform_mode_field == MODE_CLEAR_A && output_action_field == ACT_TOGGLE &&
		compare_hit
		|=> unit_a_wave_output != $past(unit_a_wave_output))
		else $error("clear-on-match toggle did not flip wave");

	a_buffer_load: assert property (
		fast && top_hit && !counter_write
		|=> compare_live == $past(compare_buffer))
		else $error("buffered compare not moved to live at ceiling");

	a_force_wave: assert property (
		force_match_strobe && !pwm && output_action_field == ACT_SET
		|=> unit_a_wave_output)
		else $error("force strobe did not apply set action");

endmodule

// ==== test/pin_load.sv ====
/*
 * Model of the external circuit on the compare output pin.
 * Assumes the pin has no pull resistor, so a released pin drifts away from
 * the last level that was driven onto it.
 */
`timescale 1ns/100ps

module pin_load
(
	input  wire logic pin_level,
	input  wire logic pin_drive_n,
	output logic      pad
);
	logic last_driven = 1'h0;

	// --------------------------------------------------------------
	// pad level
	// --------------------------------------------------------------
	always @(pin_level or pin_drive_n)
		if (!pin_drive_n)
			last_driven = pin_level;

	// floating pin shows the inverse so a stale level never passes a check
	assign pad = pin_drive_n ? ~last_driven : pin_level;
endmodule

// ==== test/testbench.sv ====
/*
 * Self-checking bench for the 16-bit timer compare and waveform block.
 * Assumes the block's registered outputs settle within 1 ns of each clock edge.
 */
`timescale 1ns/100ps

module testbench;
	import timer16_pkg::*;

	typedef struct {logic [1:0] act; logic wave;} row_t;

	logic        ref_clk = 1'h0, sys_rst = 1'h1, timer_tick = 1'h0;
	logic [3:0]  waveform_mode_field = 4'h0;
	logic [1:0]  output_action_field = 2'h0;
	logic        compare_value_high = 1'h0, compare_value_low = 1'h0;
	logic [7:0]  cpu_wdata = 8'h00;
	logic [15:0] compare_read_value, counter_value;
	logic        counter_write = 1'h0;
	logic [15:0] counter_wdata = 16'h0000, capture_value_reg = 16'h0005;
	logic        force_match_strobe = 1'h0, force_match_read, match_flag;
	logic        match_flag_clear = 1'h0, overflow_flag, overflow_flag_clear = 1'h0;
	logic        port_out_value = 1'h0, pin_direction_bit = 1'h0;
	logic        pin_level, pin_drive_n, unit_a_wave_output, pad;
	int          failures = 0, num_checks = 0;
	row_t        rows [5] = '{'{2'h3, 1'h1}, '{2'h0, 1'h1}, '{2'h1, 1'h0},
		'{2'h1, 1'h1}, '{2'h2, 1'h0}};

	always #10 ref_clk = ~ref_clk;

	timer16_compare_waveform dut (.ref_clk, .sys_rst, .timer_tick, .waveform_mode_field,
		.output_action_field, .compare_value_high, .compare_value_low, .cpu_wdata,
		.compare_read_value, .counter_write, .counter_wdata, .counter_value,
		.capture_value_reg, .force_match_strobe, .force_match_read, .match_flag,
		.match_flag_clear, .overflow_flag, .overflow_flag_clear, .port_out_value,
		.pin_direction_bit, .pin_level, .pin_drive_n, .unit_a_wave_output);

	pin_load load (.pin_level(pin_level), .pin_drive_n(pin_drive_n), .pad(pad));

	// --------------------------------------------------------------
	// tasks
	// --------------------------------------------------------------
	task automatic step(int n = 1);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// consecutive ticks keep the enable high; an idle edge follows each burst
	task automatic tick(int n);
		timer_tick = 1'h1;
		step(n);
		timer_tick = 1'h0;
		step();
	endtask

	task automatic wr_cmp(logic [15:0] v);
		compare_value_high = 1'h1;
		cpu_wdata = v[15:8];
		step();
		compare_value_high = 1'h0;
		compare_value_low = 1'h1;
		cpu_wdata = v[7:0];
		step();
		compare_value_low = 1'h0;
		step();
	endtask

	task automatic wr_cnt(logic [15:0] v);
		counter_write = 1'h1;
		counter_wdata = v;
		step();
		counter_write = 1'h0;
	endtask

	task automatic clr_flags;
		match_flag_clear = 1'h1;
		overflow_flag_clear = 1'h1;
		step();
		match_flag_clear = 1'h0;
		overflow_flag_clear = 1'h0;
	endtask

	task automatic test_done;
		if (failures == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// --------------------------------------------------------------
	// watchdog: the whole sequence needs a few hundred cycles at most
	// --------------------------------------------------------------
	initial
	begin
		#100000;
		failures++;
		test_done();
	end

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial
	begin
		step(12);
		sys_rst = 1'h0;
		step();
		chk("wave", 16'h0, unit_a_wave_output);
		chk("force_read", 16'h0, force_match_read);
		chk("counter", 16'h0, counter_value);
		chk("drive_n", 16'h1, pin_drive_n);
		chk("compare", 16'h0, compare_read_value);
		// forced matches in normal mode, timer halted
		foreach (rows[i])
		begin
			output_action_field = rows[i].act;
			force_match_strobe = 1'h1;
			step();
			force_match_strobe = 1'h0;
			step();
			chk("force_wave", rows[i].wave, unit_a_wave_output);
			chk("force_flag", 16'h0, match_flag);
			chk("force_cnt", 16'h0, counter_value);
		end
		wr_cmp(16'h1234);
		chk("cmp_read", 16'h1234, compare_read_value);
		// clear-on-match on unit A, toggling
		waveform_mode_field = MODE_CLEAR_A;
		output_action_field = ACT_TOGGLE;
		wr_cmp(16'h0003);
		tick(3);
		chk("ctc_cnt", 16'h3, counter_value);
		chk("ctc_flag0", 16'h0, match_flag);
		tick(1);
		chk("ctc_clear", 16'h0, counter_value);
		chk("ctc_flag", 16'h1, match_flag);
		chk("ctc_wave", 16'h1, unit_a_wave_output);
		clr_flags();
		chk("flag_clr", 16'h0, match_flag);
		// counter written equal to the ceiling: match lost, runs on
		wr_cnt(16'h0003);
		tick(1);
		chk("blk_cnt", 16'h4, counter_value);
		chk("blk_flag", 16'h0, match_flag);
		wr_cnt(16'hFFFF);
		tick(1);
		chk("ctc_wrap", 16'h0, counter_value);
		chk("ctc_ovf", 16'h1, overflow_flag);
		clr_flags();
		// normal mode: no clear at match, new action used at once
		waveform_mode_field = MODE_NORMAL;
		step();
		chk("mode_hold", 16'h1, unit_a_wave_output);
		output_action_field = ACT_CLEAR;
		wr_cnt(16'h0001);
		tick(3);
		chk("nrm_cnt", 16'h4, counter_value);
		chk("nrm_flag", 16'h1, match_flag);
		chk("nrm_wave", 16'h0, unit_a_wave_output);
		wr_cnt(16'hFFFE);
		tick(1);
		chk("nrm_ovf0", 16'h0, overflow_flag);
		tick(1);
		chk("nrm_wrap", 16'h0, counter_value);
		chk("nrm_ovf", 16'h1, overflow_flag);
		clr_flags();
		// pin override: wave is set up before the pin becomes an output
		port_out_value = 1'h1;
		pin_direction_bit = 1'h1;
		step(2);
		chk("pin_wave", 16'h0, pad);
		chk("drive_on", 16'h0, pin_drive_n);
		output_action_field = ACT_NONE;
		step(2);
		chk("pin_port", 16'h1, pad);
		pin_direction_bit = 1'h0;
		step(2);
		chk("drive_off", 16'h1, pin_drive_n);
		// fast PWM with capture ceiling 5, buffered compare 2
		waveform_mode_field = MODE_FAST_CAP;
		output_action_field = ACT_CLEAR;
		wr_cnt(16'h0000);
		wr_cmp(16'h0002);
		chk("buf_read", 16'h2, compare_read_value);
		tick(6);
		chk("pwm_bottom", 16'h0, counter_value);
		chk("pwm_set", 16'h1, unit_a_wave_output);
		chk("pwm_ovf", 16'h1, overflow_flag);
		tick(3);
		chk("pwm_clr", 16'h0, unit_a_wave_output);
		// fast PWM with buffered unit A ceiling: old ceiling 2, new 3 after top
		waveform_mode_field = MODE_FAST_A;
		wr_cnt(16'h0000);
		wr_cmp(16'h0003);
		tick(3);
		chk("fa_top", 16'h0, counter_value);
		tick(3);
		chk("fa_buf", 16'h3, counter_value);
		tick(1);
		chk("fa_wrap", 16'h0, counter_value);
		// fixed 8-bit ceiling
		waveform_mode_field = MODE_FAST_8;
		wr_cnt(16'h00FE);
		tick(2);
		chk("f8_top", 16'h0, counter_value);
		// clear-on-match with capture ceiling 5
		waveform_mode_field = MODE_CLEAR_CAP;
		wr_cnt(16'h0004);
		tick(2);
		chk("cap_top", 16'h0, counter_value);
		// mid-run reset clears wave, flags and compare value
		sys_rst = 1'h1;
		step();
		sys_rst = 1'h0;
		step();
		chk("rst_wave", 16'h0, unit_a_wave_output);
		chk("rst_cnt", 16'h0, counter_value);
		chk("rst_flag", 16'h0, match_flag);
		chk("rst_ovf", 16'h0, overflow_flag);
		chk("rst_cmp", 16'h0, compare_read_value);
		chk("rst_drive", 16'h1, pin_drive_n);
		test_done();
	end
endmodule
